// ### design/pfcs_host.v
// Host-side command sequencer driving a parallel NOR flash over its strobe pins
`timescale 1ns/1ps
`include "pfcs_map.vh"
// Summary of operation
// - Program: two unlock cycles, A0h, then address/data
// - Chip erase: six cycles ending 555h/10h
// - Block erase: sixth cycle block address, 30h
// - Lockout enable: six cycles ending 40h
// - Lockout detect read at boot address
// - Identification exit: three-cycle or single F0h
// - Identification entry: third cycle 90h
// - Read: chip select, output strobe low
module pfcs_host
(
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // User request
  input wire req_valid,
  output wire req_ready,
  input wire [2:0] req_op,
  input wire [17:0] req_addr,
  input wire [7:0] req_data,
  // User answer
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  output reg busy,
  // Flash pins
  output reg [17:0] flash_addr,
  output reg flash_ce_n,
  output reg flash_we_n,
  output reg flash_oe_n,
  input wire [7:0] flash_dq_in,
  output reg [7:0] flash_dq_out,
  output reg flash_dq_oe
);
  // ****************************************
  // State and sequence holding
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_WPULSE = 3'h2;
  localparam [2:0] ST_RPULSE = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_POLL = 3'h5;
  localparam [31:0] PULSE_W = `PFCS_T_PULSE_CYC; // Full width, cut to the counter below
  localparam [31:0] SETUP_W = `PFCS_T_SETUP_CYC;
  localparam [31:0] READ_W = `PFCS_T_READ_CYC;
  localparam [7:0] PULSE_CYC = PULSE_W[7:0];
  localparam [7:0] SETUP_CYC = SETUP_W[7:0];
  localparam [7:0] READ_CYC = READ_W[7:0];
  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg [2:0] step_q;
  reg [2:0] nsteps_q;
  reg [2:0] op_q;
  reg [17:0] addr_q;
  reg [7:0] data_q;
  reg poll_prev_q;
  reg poll_have_q;
  wire [7:0] dq_sync;

  pfcs_sync u_sync
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(flash_dq_in),
    .sync_out(dq_sync)
  );

  assign req_ready = (state_q == ST_IDLE);

  // ****************************************
  // Bus-cycle address and data per step
  // ****************************************
  reg [17:0] cyc_addr;
  reg [7:0] cyc_data;
  always @*
  begin
    cyc_addr = `PFCS_UNLOCK_ADDR1;
    cyc_data = `PFCS_UNLOCK_DATA1;
    case (step_q)
      3'h0:
        if (op_q == `PFCS_OP_ID_EXIT_SHORT)
        begin
          cyc_addr = addr_q;
          cyc_data = `PFCS_CMD_ID_EXIT;
        end
      3'h1, 3'h4:
      begin
        cyc_addr = `PFCS_UNLOCK_ADDR2;
        cyc_data = `PFCS_UNLOCK_DATA2;
      end
      3'h2:
        case (op_q)
          `PFCS_OP_PROGRAM: cyc_data = `PFCS_CMD_PROGRAM;
          `PFCS_OP_ID_ENTRY: cyc_data = `PFCS_CMD_ID_ENTRY;
          `PFCS_OP_ID_EXIT: cyc_data = `PFCS_CMD_ID_EXIT;
          default: cyc_data = `PFCS_CMD_ERASE_SETUP;
        endcase
      3'h3:
        if (op_q == `PFCS_OP_PROGRAM)
        begin
          cyc_addr = addr_q;
          cyc_data = data_q;
        end
      3'h5:
        case (op_q)
          `PFCS_OP_CHIP_ERASE: cyc_data = `PFCS_CMD_CHIP_ERASE;
          `PFCS_OP_LOCKOUT: cyc_data = `PFCS_CMD_LOCKOUT;
          default:
          begin
            cyc_addr = addr_q;
            cyc_data = `PFCS_CMD_BLOCK_ERASE;
          end
        endcase
      default:
      begin
        cyc_addr = addr_q;
        cyc_data = 8'h00;
      end
    endcase
  end

  // Cycle count per operation; reads and polls have none
  reg [2:0] req_steps;
  always @*
  begin
    case (req_op)
      `PFCS_OP_PROGRAM: req_steps = 3'h4;
      `PFCS_OP_CHIP_ERASE, `PFCS_OP_BLOCK_ERASE, `PFCS_OP_LOCKOUT: req_steps = 3'h6;
      `PFCS_OP_ID_ENTRY, `PFCS_OP_ID_EXIT: req_steps = 3'h3;
      `PFCS_OP_ID_EXIT_SHORT: req_steps = 3'h1;
      default: req_steps = 3'h0;
    endcase
  end

  // Program and erase wait for completion before the next command
  wire op_embedded = (op_q == `PFCS_OP_PROGRAM) || (op_q == `PFCS_OP_CHIP_ERASE) ||
    (op_q == `PFCS_OP_BLOCK_ERASE);
  wire wr_step = (step_q < nsteps_q); // Step left to write, else a read
  // Bit6 stop toggling marks the end; status bits sampled on each poll read
  wire poll_done = poll_have_q && (poll_prev_q == dq_sync[6]);

  // ****************************************
  // Main sequencer
  // ****************************************
  // Write pulses stay longer than the device glitch filter
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      step_q <= 3'h0;
      nsteps_q <= 3'h0;
      op_q <= 3'h0;
      addr_q <= 18'h00000;
      data_q <= 8'h00;
      poll_prev_q <= 1'b0;
      poll_have_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      busy <= 1'b0;
      flash_addr <= 18'h00000;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (cnt_q != 8'h00) // Shared down-counter; a state reloads it at zero
        cnt_q <= cnt_q - 8'h01;
      case (state_q)
        ST_IDLE:
        begin
          flash_ce_n <= 1'b1;
          flash_oe_n <= 1'b1;
          flash_we_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          if (req_valid)
          begin
            op_q <= req_op;
            addr_q <= req_addr;
            data_q <= req_data;
            nsteps_q <= req_steps;
            step_q <= 3'h0;
            busy <= 1'b1;
            poll_have_q <= 1'b0;
            cnt_q <= SETUP_CYC;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          // Address and data settle with strobes high, output strobe off
          flash_addr <= wr_step ? cyc_addr : addr_q;
          flash_dq_out <= cyc_data;
          flash_dq_oe <= wr_step;
          flash_oe_n <= 1'b1;
          if (cnt_q == 8'h00)
          begin
            flash_ce_n <= 1'b0;
            if (wr_step)
            begin
              flash_we_n <= 1'b0;
              cnt_q <= PULSE_CYC;
              state_q <= ST_WPULSE;
            end
            else
            begin
              flash_oe_n <= 1'b0;
              cnt_q <= READ_CYC;
              state_q <= ST_RPULSE;
            end
          end
        end
        ST_WPULSE:
        begin
          // Data held until after both strobes rise
          if (cnt_q == 8'h00)
          begin
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            step_q <= step_q + 3'h1;
            cnt_q <= SETUP_CYC;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (cnt_q == 8'h00)
          begin
            flash_dq_oe <= 1'b0;
            if (wr_step || op_embedded)
            begin
              cnt_q <= SETUP_CYC;
              state_q <= ST_SETUP;
            end
            else
            begin
              busy <= 1'b0;
              rsp_valid <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_RPULSE:
        begin
          if (cnt_q == 8'h00)
          begin
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            state_q <= ST_POLL;
          end
        end
        ST_POLL:
        begin
          // Synchroniser latency covered by the read pulse length
          poll_prev_q <= dq_sync[6];
          poll_have_q <= 1'b1;
          if (!op_embedded || poll_done)
          begin
            rsp_data <= dq_sync;
            rsp_valid <= 1'b1;
            busy <= 1'b0;
            state_q <= ST_IDLE;
          end
          else
          begin
            cnt_q <= SETUP_CYC;
            state_q <= ST_SETUP;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // pfcs_host

// ### design/pfcs_sync.v
// Two-flop synchroniser for the flash data pins
`timescale 1ns/1ps
module pfcs_sync
(
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Pin side
  input wire [7:0] pin_in,
  // Synchronised side
  output wire [7:0] sync_out
);
  reg [7:0] meta_q;
  reg [7:0] sync_q;

  // First stage feeds only the second
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // pfcs_sync

// ### include/pfcs_map.vh
// Bus-cycle codes, addresses and timing counts of the flash command sequencer
`ifndef PFCS_MAP_VH
`define PFCS_MAP_VH
// Unlock addresses and data
`define PFCS_UNLOCK_ADDR1 18'h00555
`define PFCS_UNLOCK_ADDR2 18'h002aa
`define PFCS_UNLOCK_DATA1 8'haa
`define PFCS_UNLOCK_DATA2 8'h55
// Third / sixth cycle command codes
`define PFCS_CMD_PROGRAM 8'ha0
`define PFCS_CMD_ERASE_SETUP 8'h80
`define PFCS_CMD_CHIP_ERASE 8'h10
`define PFCS_CMD_BLOCK_ERASE 8'h30
`define PFCS_CMD_LOCKOUT 8'h40
`define PFCS_CMD_ID_ENTRY 8'h90
`define PFCS_CMD_ID_EXIT 8'hf0
// Operation codes on the user port
`define PFCS_OP_READ 3'h0
`define PFCS_OP_PROGRAM 3'h1
`define PFCS_OP_CHIP_ERASE 3'h2
`define PFCS_OP_BLOCK_ERASE 3'h3
`define PFCS_OP_LOCKOUT 3'h4
`define PFCS_OP_ID_ENTRY 3'h5
`define PFCS_OP_ID_EXIT 3'h6
`define PFCS_OP_ID_EXIT_SHORT 3'h7
// Lockout detection read: A1 high, A0 low, A14-A17 at boot block
`define PFCS_LOCK_DET_LOW 2'h2
`define PFCS_BOOT_TOP 4'hf
`define PFCS_BOOT_BOTTOM 4'h0
`define PFCS_ID_MAKER_OFS 8'h00
`define PFCS_ID_DEVICE_OFS 8'h01
// Bus timing in ns and cycles at 4 ns; pulses stay well above 20 ns glitch width
`define PFCS_CLK_NS 4
`define PFCS_T_PULSE_NS 60
`define PFCS_T_PULSE_CYC ((`PFCS_T_PULSE_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_T_SETUP_NS 20
`define PFCS_T_SETUP_CYC ((`PFCS_T_SETUP_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_T_READ_NS 100
`define PFCS_T_READ_CYC ((`PFCS_T_READ_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`endif

// ### test/pfcs_flash_model.sv
// Behavioural parallel flash with command decode, embedded operations and status
`timescale 1ns/1ps
module pfcs_flash_model
#(
  parameter BUSY_READS = 3,
  parameter BOOT_TOP = 1
)
(
  // Flash pins
  input wire [17:0] addr,
  input wire ce_n,
  input wire we_n,
  input wire oe_n,
  input wire [7:0] din,
  output reg [7:0] dout
);
  // ****
  // Array
  // ****
  reg [7:0] mem [0:262143];
  reg [7:0] last = 8'hff;
  reg [17:0] wa = 18'h0;
  reg su = 0, pg = 0, idm = 0, lock = 0, ers = 0, tg = 0;
  integer st = 0, busy = 0, i;
  realtime t0 = 0;
  wire wr = !(ce_n || we_n) && oe_n;
  wire rd = !(ce_n || oe_n) && we_n;
  wire [7:0] stat = {ers ? 1'b0 : ~last[7], tg, last[5:0]};
  // Block index, 4 is boot; top-boot or bottom-boot map
  function integer blk(input [17:0] a);
    if (BOOT_TOP)
      blk = !a[17] ? 0 : a[16:15] != 2'h3 ? 1 : a[14] ? 4 : a[13] ? 3 : 2;
    else
      blk = a[17] ? 0 : a[16:15] != 2'h0 ? 1 : !a[14] ? 4 : a[13] ? 3 : 2;
  endfunction
  // Erased at start
  initial
  begin
    dout = 8'h00;
    for (i = 0; i < 262144; i = i + 1)
      mem[i] = 8'hff;
  end
  // Address at the later falling strobe, when the write cycle opens
  always @(posedge wr)
  begin
    wa = addr;
    t0 = $realtime;
  end
  // Data at the earlier rising strobe; glitches and writes while busy dropped
  always @(negedge wr)
    if (busy == 0 && $realtime - t0 >= 20)
    begin
      if (pg)
      begin
        pg = 0;
        last = din;
        if (!(lock && blk(wa) == 4))
        begin
          mem[wa] = mem[wa] & din;
          busy = BUSY_READS;
          ers = 0;
          tg = ~mem[wa][6];
        end
      end
      else if (din == 8'hf0)
      begin
        idm = 0;
        st = 0;
      end
      else if (st < 2)
        st = (din == (st ? 8'h55 : 8'haa) && wa == (st ? 18'h2aa : 18'h555)) ? st + 1 : 0;
      else
      begin
        st = 0;
        pg = !su && din == 8'ha0;
        if (!su && din == 8'h90)
          idm = 1;
        if (su && din == 8'h40 && wa == 18'h555)
        begin
          lock = 1;
          idm = 1;
        end
        if (su && (din == 8'h10 || din == 8'h30 && !(lock && blk(wa) == 4)))
        begin
          for (i = 0; i < 262144; i = i + 1)
            if ((din == 8'h10 || blk(i[17:0]) == blk(wa)) && !(lock && blk(i[17:0]) == 4))
              mem[i] = 8'hff;
          busy = BUSY_READS;
          ers = 1;
          tg = 0;
        end
        su = din == 8'h80 && !su;
      end
    end
  // Each finished read while busy flips the toggle bit
  always @(negedge rd)
    if (busy > 0)
    begin
      busy = busy - 1;
      tg = ~tg;
    end
  // Pins wander when not read, so stale data cannot pass
  always @(rd or addr or busy or tg)
    dout = !rd ? ~dout : busy > 0 ? stat :
      idm && addr[1:0] == 2'h2 && addr[17:14] == (BOOT_TOP ? 4'hf : 4'h0) ?
      {7'h0, lock} : mem[addr];
endmodule // pfcs_flash_model

// ### test/pfcs_host_chk.sv
// Assertion checker on the sequencer's user handshake and flash pins
`timescale 1ns/1ps
module pfcs_host_chk
(
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // User side
  input wire req_valid,
  input wire req_ready,
  input wire rsp_valid,
  input wire busy,
  // Flash pins
  input wire [17:0] flash_addr,
  input wire flash_ce_n,
  input wire flash_we_n,
  input wire flash_oe_n,
  input wire [7:0] flash_dq_out,
  input wire flash_dq_oe
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_we_low; !flash_we_n [*5]; endsequence
  sequence s_ce_low; !flash_ce_n [*5]; endsequence
  sequence s_wr; !flash_we_n && !flash_ce_n; endsequence
  property p_we_wide; $fell(flash_we_n) |-> s_we_low; endproperty
  property p_ce_wide; $fell(flash_ce_n) |-> s_ce_low; endproperty
  property p_no_rd_wr; flash_we_n || flash_oe_n; endproperty
  property p_wr_hold; s_wr ##1 s_wr |-> $stable(flash_addr) && $stable(flash_dq_out); endproperty
  property p_drive; !flash_we_n |-> flash_dq_oe; endproperty
  property p_release; !flash_oe_n |-> !flash_dq_oe; endproperty
  property p_take; req_valid && req_ready |=> busy && !req_ready; endproperty
  property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_we_wide: assert property (p_we_wide)
    else $error("write strobe pulse too short");
  a_ce_wide: assert property (p_ce_wide)
    else $error("select pulse too short");
  a_no_rd_wr: assert property (p_no_rd_wr)
    else $error("write with output strobe low");
  a_wr_hold: assert property (p_wr_hold)
    else $error("address or data moved in write");
  a_drive: assert property (p_drive)
    else $error("data not driven in write");
  a_release: assert property (p_release)
    else $error("host drives bus in read");
  a_take: assert property (p_take)
    else $error("request taken but not busy");
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("answer longer than one cycle");
endmodule // pfcs_host_chk

// ### test/pfcs_host_tb.sv
// Self-checking bench: host sequencer driving the behavioural flash
`timescale 1ns/1ps
module pfcs_host_tb;
  // ****
  // Harness
  // ****
  reg ref_clk = 0, rst = 1, req_valid = 0;
  reg [2:0] req_op = 3'h0;
  reg [17:0] req_addr = 18'h0;
  reg [7:0] req_data = 8'h00;
  wire req_ready, rsp_valid, busy, ce_n, we_n, oe_n, dq_oe;
  wire [7:0] rsp_data, dq_out, mdl_dq;
  wire [17:0] fa;
  integer num_errors = 0, compares = 0;
  // Host drive wins on the shared data wire
  wire [7:0] dq = dq_oe ? dq_out : mdl_dq;
  pfcs_host u_dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy), .flash_addr(fa),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_dq_in(dq),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
  pfcs_flash_model u_flash (.addr(fa), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .din(dq), .dout(mdl_dq));
  task final_report;
    begin
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [8*6:1] nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("mismatch %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One operation; held until taken, answer awaited with a bound
  task run(input [2:0] o, input [17:0] a, input [7:0] d);
    integer n;
    begin
      @(negedge ref_clk);
      while (req_ready !== 1'b1)
        @(negedge ref_clk);
      req_valid = 1;
      req_op = o;
      req_addr = a;
      req_data = d;
      @(negedge ref_clk);
      req_valid = 0;
      for (n = 0; n < 5000 && rsp_valid !== 1'b1; n = n + 1)
        @(negedge ref_clk);
      chk("answer", 8'h01, {7'h0, rsp_valid});
    end
  endtask
  // ****
  // Scenarios
  // ****
  task t_prog;
    begin
      run(3'h1, 18'h01234, 8'h5a);
      chk("prog", 8'h5a, rsp_data);
      run(3'h1, 18'h01234, 8'h0f);
      chk("clear", 8'h0a, rsp_data);
      run(3'h0, 18'h01234, 8'h00);
      chk("read", 8'h0a, rsp_data);
      $display("prog done");
    end
  endtask
  task t_erase;
    begin
      run(3'h1, 18'h38000, 8'h00);
      run(3'h3, 18'h00100, 8'h00);
      chk("ebit7", 8'h01, {7'h0, rsp_data[7]});
      run(3'h0, 18'h01234, 8'h00);
      chk("blk", 8'hff, rsp_data);
      run(3'h0, 18'h38000, 8'h00);
      chk("other", 8'h00, rsp_data);
      run(3'h2, 18'h00000, 8'h00);
      run(3'h0, 18'h38000, 8'h00);
      chk("chip", 8'hff, rsp_data);
      $display("erase done");
    end
  endtask
  task t_ident;
    begin
      run(3'h5, 18'h0, 8'h00);
      run(3'h0, 18'h3c002, 8'h00);
      chk("lock0", 8'h00, {7'h0, rsp_data[0]});
      run(3'h6, 18'h0, 8'h00);
      run(3'h0, 18'h3c002, 8'h00);
      chk("exit3", 8'hff, rsp_data);
      $display("ident done");
    end
  endtask
  task t_lock;
    begin
      run(3'h1, 18'h3c010, 8'h00);
      run(3'h4, 18'h0, 8'h00);
      run(3'h0, 18'h3c002, 8'h00);
      chk("lock1", 8'h01, {7'h0, rsp_data[0]});
      run(3'h7, 18'h12345, 8'h00);
      run(3'h0, 18'h3c002, 8'h00);
      chk("exit1", 8'hff, rsp_data);
      run(3'h3, 18'h3c000, 8'h00);
      run(3'h0, 18'h3c010, 8'h00);
      chk("bootbe", 8'h00, rsp_data);
      run(3'h1, 18'h01234, 8'h00);
      run(3'h2, 18'h00000, 8'h00);
      run(3'h0, 18'h3c010, 8'h00);
      chk("bootce", 8'h00, rsp_data);
      run(3'h0, 18'h01234, 8'h00);
      chk("maince", 8'hff, rsp_data);
      $display("lock done");
    end
  endtask
  // Main sequence after a 12 cycle reset
  initial
  begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 0;
    t_prog;
    t_erase;
    t_ident;
    t_lock;
    final_report;
  end
  // Watchdog at 30000 cycles, close to nine times the expected run
  initial
  begin
    #120000;
    num_errors = num_errors + 1;
    final_report;
  end
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
endmodule // pfcs_host_tb
bind pfcs_host pfcs_host_chk u_chk (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .busy(busy), .flash_addr(flash_addr),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
